/* File: timed_write_protection.sv */
// timed write protection: two-key unlock sequencer, timed write window,
// page select register and the protected control registers it gates
// assumes one cpu write or read request per cycle on core_clk, same domain
`timescale 1ns/100ps

module timed_write_protection (
  input  wire logic                                core_clk,
  input  wire logic                                reset_n,
  input  wire timed_write_protection_pkg::sfr_req_t sfr_req,
  output      timed_write_protection_pkg::sfr_rsp_t sfr_rsp,
  output      logic                                window_open,
  output      logic                                page_select_bit,
  output      logic [7:0]                          watchdog_control,
  output      logic [7:0]                          brownout_control_a
);

  // ************************************************************
  // state
  // ************************************************************
  timed_write_protection_pkg::seq_state_t seq_reg;
  timed_write_protection_pkg::seq_state_t seq_next;
  timed_write_protection_pkg::sfr_rsp_t   rsp_reg;
  timed_write_protection_pkg::sfr_rsp_t   rsp_next;
  logic [2:0]                             arm_cnt_reg;
  logic [2:0]                             arm_cnt_next;
  logic [2:0]                             win_cnt_reg;
  logic [2:0]                             win_cnt_next;
  logic [7:0]                             timed_access_key_reg;
  logic [7:0]                             register_page_select_reg;
  logic [7:0]                             watchdog_control_reg;
  logic [7:0]                             brownout_control_a_reg;
  logic                                   window_open_reg;

  // ************************************************************
  // decode
  // ************************************************************
  logic key_wr;
  logic page_wr;
  logic on_prot_page;
  logic wdog_wr;
  logic bod_wr;
  logic win_active;
  logic unlock;

  // key and page select are decoded on every page
  assign key_wr  = sfr_req.wr &&
                   (sfr_req.addr == timed_write_protection_pkg::key_addr);
  assign page_wr = sfr_req.wr &&
                   (sfr_req.addr == timed_write_protection_pkg::page_select_addr);

  // current page comes from the page select bit
  assign on_prot_page =
    (register_page_select_reg[timed_write_protection_pkg::page_bit_pos] ==
     timed_write_protection_pkg::protected_page);

  assign wdog_wr = sfr_req.wr && on_prot_page &&
                   (sfr_req.addr == timed_write_protection_pkg::watchdog_addr);
  assign bod_wr  = sfr_req.wr && on_prot_page &&
                   (sfr_req.addr == timed_write_protection_pkg::brownout_addr);

  // a page select or protected register write is taken only at an edge where the window is still counting
  assign win_active = (win_cnt_reg != 3'h0);

  // second key accepted in any of the three cycles after the first
  assign unlock = key_wr &&
                  (seq_reg == timed_write_protection_pkg::seq_armed) &&
                  (arm_cnt_reg != 3'h0) &&
                  (sfr_req.wdata == timed_write_protection_pkg::second_key);

  // ************************************************************
  // unlock sequencer
  // ************************************************************
  always_comb begin
    seq_next     = seq_reg;
    arm_cnt_next = arm_cnt_reg;
    case (seq_reg)
      timed_write_protection_pkg::seq_idle: begin
        arm_cnt_next = 3'h0;
        if (key_wr && (sfr_req.wdata == timed_write_protection_pkg::first_key)) begin
          seq_next     = timed_write_protection_pkg::seq_armed;
          arm_cnt_next = timed_write_protection_pkg::arm_cycles;
        end
      end
      timed_write_protection_pkg::seq_armed: begin
        if (arm_cnt_reg != 3'h0) begin
          arm_cnt_next = arm_cnt_reg - 3'h1;
        end
        if (key_wr && (sfr_req.wdata == timed_write_protection_pkg::first_key)) begin
          // a fresh first key restarts the wait
          arm_cnt_next = timed_write_protection_pkg::arm_cycles;
        end else if (unlock) begin
          seq_next     = timed_write_protection_pkg::seq_idle;
          arm_cnt_next = 3'h0;
        end else if (key_wr) begin
          seq_next     = timed_write_protection_pkg::seq_idle;
          arm_cnt_next = 3'h0;
        end else if (arm_cnt_reg == 3'h0) begin
          seq_next     = timed_write_protection_pkg::seq_idle;
        end
      end
      default: begin
        seq_next     = timed_write_protection_pkg::seq_idle;
        arm_cnt_next = 3'h0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_reg     <= timed_write_protection_pkg::seq_idle;
      arm_cnt_reg <= 3'h0;
    end else begin
      seq_reg     <= seq_next;
      arm_cnt_reg <= arm_cnt_next;
    end
  end

  // ************************************************************
  // write window
  // ************************************************************
  // only elapsed cycles close the window; writes inside it do not
  always_comb begin
    win_cnt_next = win_cnt_reg;
    if (unlock) begin
      win_cnt_next = timed_write_protection_pkg::window_cycles;
    end else if (win_cnt_reg != 3'h0) begin
      win_cnt_next = win_cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      win_cnt_reg     <= 3'h0;
      window_open_reg <= 1'b0;
    end else begin
      win_cnt_reg     <= win_cnt_next;
      window_open_reg <= (win_cnt_next != 3'h0);
    end
  end

  // ************************************************************
  // key register
  // ************************************************************
  // holds the last key written; never returned on a read
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      timed_access_key_reg <= timed_write_protection_pkg::key_reset;
    end else if (key_wr) begin
      timed_access_key_reg <= sfr_req.wdata;
    end
  end

  // ************************************************************
  // page select register
  // ************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      register_page_select_reg <= timed_write_protection_pkg::page_select_reset;
    end else if (page_wr && win_active) begin
      register_page_select_reg <= {7'h00,
        sfr_req.wdata[timed_write_protection_pkg::page_bit_pos]};
    end
  end

  // ************************************************************
  // protected control registers
  // ************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_control_reg <= timed_write_protection_pkg::watchdog_reset;
    end else if (wdog_wr && win_active) begin
      watchdog_control_reg <= sfr_req.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      brownout_control_a_reg <= timed_write_protection_pkg::brownout_reset;
    end else if (bod_wr && win_active) begin
      brownout_control_a_reg <= sfr_req.wdata;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  // reads never look at the window; unmapped and key reads give zero
  always_comb begin
    rsp_next.valid = sfr_req.rd;
    rsp_next.rdata = 8'h00;
    if (sfr_req.rd) begin
      if (sfr_req.addr == timed_write_protection_pkg::page_select_addr) begin
        rsp_next.rdata = register_page_select_reg;
      end else if (on_prot_page &&
                   (sfr_req.addr == timed_write_protection_pkg::watchdog_addr)) begin
        rsp_next.rdata = watchdog_control_reg;
      end else if (on_prot_page &&
                   (sfr_req.addr == timed_write_protection_pkg::brownout_addr)) begin
        rsp_next.rdata = brownout_control_a_reg;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign sfr_rsp            = rsp_reg;
  assign window_open        = window_open_reg;
  assign page_select_bit    =
    register_page_select_reg[timed_write_protection_pkg::page_bit_pos];
  assign watchdog_control   = watchdog_control_reg;
  assign brownout_control_a = brownout_control_a_reg;

endmodule

/* File: timed_write_protection_pkg.sv */
// timed write protection package: addresses, reset values, key values, counts
// assumes a single special-function-register bus driven by the cpu core
package timed_write_protection_pkg;

  // ************************************************************
  // addresses
  // ************************************************************
  localparam logic [7:0] key_addr           = 8'hc7;
  localparam logic [7:0] page_select_addr   = 8'h91;
  localparam logic [7:0] watchdog_addr      = 8'haa;
  localparam logic [7:0] brownout_addr      = 8'ha3;
  localparam logic       protected_page     = 1'h0;

  // ************************************************************
  // fields and reset values
  // ************************************************************
  localparam int         page_bit_pos       = 0;
  localparam logic [7:0] key_reset          = 8'h00;
  localparam logic [7:0] page_select_reset  = 8'h00;
  localparam logic [7:0] watchdog_reset     = 8'h00;
  localparam logic [7:0] brownout_reset     = 8'h00;

  // ************************************************************
  // keys and timing
  // ************************************************************
  localparam logic [7:0] first_key          = 8'haa;
  localparam logic [7:0] second_key         = 8'h55;
  localparam logic [2:0] arm_cycles         = 3'h3;
  localparam logic [2:0] window_cycles      = 3'h4;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    seq_idle  = 2'b01,
    seq_armed = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } sfr_rsp_t;

endpackage

/* File: cpu_model.sv */
// cpu core model: one-cycle sfr write and read requests
// assumes core_clk from the bench; requests change just after a rising edge
`timescale 1ns/100ps
module cpu_model (
  input  wire logic                                 core_clk,
  output      timed_write_protection_pkg::sfr_req_t sfr_req
);
  initial sfr_req = '0;
  // one request, held until the edge that takes it
  task automatic issue(input logic w, input logic [7:0] a, input logic [7:0] d);
    sfr_req <= {w, ~w, a, d};
    @(posedge core_clk);
  endtask
  // idle bus: address and data toggle so stale values never look held
  task automatic idle(input int n);
    sfr_req <= {2'b00, ~sfr_req.addr, ~sfr_req.wdata};
    repeat (n) @(posedge core_clk);
  endtask
endmodule

/* File: timed_write_protection_assertions.sv */
// checker: unlock timing, window length, gated writes, read answers
// assumes only the top module ports, bound after the module
`timescale 1ns/100ps
module timed_write_protection_assertions (
  input wire logic                                 core_clk,
  input wire logic                                 reset_n,
  input wire timed_write_protection_pkg::sfr_req_t sfr_req,
  input wire timed_write_protection_pkg::sfr_rsp_t sfr_rsp,
  input wire logic                                 window_open,
  input wire logic                                 page_select_bit,
  input wire logic [7:0]                           watchdog_control,
  input wire logic [7:0]                           brownout_control_a
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire kw = sfr_req.wr && sfr_req.addr == timed_write_protection_pkg::key_addr;
  wire k1 = kw && sfr_req.wdata == timed_write_protection_pkg::first_key;
  wire k2 = kw && sfr_req.wdata == timed_write_protection_pkg::second_key;
  wire wd = sfr_req.wr && sfr_req.addr == timed_write_protection_pkg::watchdog_addr;
  wire bo = sfr_req.wr && sfr_req.addr == timed_write_protection_pkg::brownout_addr;
  wire ps = sfr_req.wr && sfr_req.addr == timed_write_protection_pkg::page_select_addr;
  unlock_opens_a: assert property (k1 ##1 k2 |=> window_open)
    else $error("unlock opened no window");
  window_length_a: assert property ($rose(window_open) |-> window_open[*4])
    else $error("window shorter than four cycles");
  window_close_a: assert property ($rose(window_open) ##0 (!k2)[*4] |=> !window_open)
    else $error("window did not close");
  late_key_a: assert property (k1 && !window_open ##1 (!kw)[*3] ##1 k2 |=> !window_open)
    else $error("late key opened window");
  locked_write_a: assert property ((wd || bo) && !window_open |=>
    $stable(watchdog_control) && $stable(brownout_control_a)) else $error("locked write took");
  open_write_a: assert property (wd && window_open && !page_select_bit |=>
    watchdog_control == $past(sfr_req.wdata)) else $error("open write lost");
  page_gate_a: assert property (ps && !window_open |=> $stable(page_select_bit))
    else $error("locked page write took");
  page_write_a: assert property (ps && window_open |=>
    page_select_bit == $past(sfr_req.wdata[0])) else $error("page write lost");
  read_answer_a: assert property (sfr_req.rd && !page_select_bit &&
    sfr_req.addr == timed_write_protection_pkg::watchdog_addr |=>
    sfr_rsp.valid && sfr_rsp.rdata == $past(watchdog_control)) else $error("bad read");
endmodule
bind timed_write_protection timed_write_protection_assertions timed_write_protection_assertions_inst (
  .core_clk(core_clk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rsp(sfr_rsp),
  .window_open(window_open), .page_select_bit(page_select_bit),
  .watchdog_control(watchdog_control), .brownout_control_a(brownout_control_a));

/* File: tb_timed_write_protection.sv */
// bench: unlock timing, window length and gated writes through the cpu model
// assumes package, design, cpu model and checker compiled first
`timescale 1ns/100ps
module tb_timed_write_protection;
  localparam logic [7:0] ky = timed_write_protection_pkg::key_addr;
  localparam logic [7:0] wd = timed_write_protection_pkg::watchdog_addr;
  localparam logic [7:0] bo = timed_write_protection_pkg::brownout_addr;
  localparam logic [7:0] ps = timed_write_protection_pkg::page_select_addr;
  logic                                 core_clk = 1'b0;
  logic                                 reset_n  = 1'b0;
  timed_write_protection_pkg::sfr_req_t sfr_req;
  timed_write_protection_pkg::sfr_rsp_t sfr_rsp;
  logic                                 window_open;
  logic                                 page_select_bit;
  logic [7:0]                           watchdog_control;
  logic [7:0]                           brownout_control_a;
  logic [7:0]                           wd_exp = 8'h00;
  logic [7:0]                           bo_exp = 8'h00;
  int                                   error_cnt = 0;
  int                                   samples_checked = 0;
  always #25 core_clk = ~core_clk;
  cpu_model cpu_model_inst (.core_clk(core_clk), .sfr_req(sfr_req));
  timed_write_protection timed_write_protection_inst (.core_clk(core_clk), .reset_n(reset_n),
    .sfr_req(sfr_req), .sfr_rsp(sfr_rsp), .window_open(window_open),
    .page_select_bit(page_select_bit), .watchdog_control(watchdog_control),
    .brownout_control_a(brownout_control_a));
  // ******
  // tasks
  // ******
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // read answer is registered at the taking edge and checked 1 ns after it
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cpu_model_inst.issue(1'b0, a, 8'h00);
    cpu_model_inst.idle(0);
    #1;
    chk({7'h00, sfr_rsp.valid}, 8'h01);
    chk(sfr_rsp.rdata, exp);
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu_model_inst.issue(1'b1, a, d);
  endtask
  // idle long enough to close any window, then key pair with gap idle edges
  task automatic unlock(input int gap);
    cpu_model_inst.idle(6);
    wr(ky, timed_write_protection_pkg::first_key);
    if (gap > 0) cpu_model_inst.idle(gap);
    wr(ky, timed_write_protection_pkg::second_key);
  endtask
  task automatic results();
    $display("mismatches %0d, comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd(wd, 8'h00);
    rd(bo, 8'h00);
    rd(ps, 8'h00);
    rd(ky, 8'h00);
    rd(8'ha1, 8'h00);
    wr(wd, 8'h5a);
    rd(wd, wd_exp);
    for (int g = 0; g < 4; g++) begin
      unlock(g);
      wr(bo, 8'h10 + g[7:0]);
      if (g < 3) bo_exp = 8'h10 + g[7:0];
      rd(bo, bo_exp);
    end
    for (int d = 0; d < 5; d++) begin
      unlock(0);
      if (d > 0) cpu_model_inst.idle(d);
      wr(wd, 8'h40 + d[7:0]);
      if (d < 4) wd_exp = 8'h40 + d[7:0];
      rd(wd, wd_exp);
    end
    unlock(0);
    wr(wd, 8'h61);
    cpu_model_inst.idle(3);
    wr(bo, 8'h62);
    rd(wd, 8'h61);
    rd(bo, bo_exp);
    wd_exp = 8'h61;
    cpu_model_inst.idle(6);
    wr(ky, timed_write_protection_pkg::first_key);
    wr(ky, 8'h12);
    wr(ky, timed_write_protection_pkg::second_key);
    wr(wd, 8'h77);
    rd(wd, wd_exp);
    wr(ps, 8'h01);
    rd(ps, 8'h00);
    unlock(0);
    wr(ps, 8'h01);
    rd(ps, 8'h01);
    chk({7'h00, page_select_bit}, 8'h01);
    rd(wd, 8'h00);
    rd(ky, 8'h00);
    unlock(0);
    wr(ps, 8'h00);
    rd(wd, wd_exp);
    chk(watchdog_control, wd_exp);
    chk(brownout_control_a, bo_exp);
    results();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    error_cnt++;
    results();
  end
endmodule
